// ---- rtl/nfpc_host.sv ----
// Host controller: feature write, status polling and write-protect sequencing
//
// Behaviour
// [RULE1] Feature write opens with command EFh then exactly one feature address cycle.
// [RULE2] Four parameter bytes follow in order, each latched on write strobe rise.
// [RULE3] Device holds ready-busy low while storing parameters, then releases high.
// [RULE4] Device feature busy period lasts at most one microsecond.
// [RULE5] Status read 70h is accepted during feature write for completion polling.
// [RULE6] Device keeps feature parameters until a power cycle.
// [RULE7] Device stays in feature mode until another valid command arrives.
// [RULE8] One-time area pages of 2112 bytes reachable only by dedicated commands.
// [RULE9] One-time area ships all ones, cannot be erased; protect only blocks program.
// [RULE10] Write-protect level enables or inhibits program and erase.
// [RULE11] Change write-protect at least 100 ns before first affected command latch.
// [RULE12] Hold write-protect steady until operation completes and status bit 5 is 1.
// [RULE13] Device supports block locking of whole array or a block range.
// [RULE14] Wait at least 1 ms after power-up before any command.
// [RULE15] Hold write-protect low during power-up and power-down.
// [RULE16] Leave at least 70 ns from last address strobe rise to first data rise.
// [RULE17] Issue no command but status read while ready-busy low after feature write.
`timescale 1ns/1ns
`default_nettype none
module nfpc_host #(
    parameter int unsigned POWER_UP_CYC = nfpc_pkg::POWER_UP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        feat_req,
    input  wire logic [7:0]  feat_addr,
    input  wire logic [31:0] feat_params,
    input  wire logic        poll_status,
    input  wire logic        wp_allow,
    output logic             feat_done,
    output logic [7:0]       status_byte,
    output logic             ctrl_ready,
    output logic             nand_cle,
    output logic             nand_ale,
    output logic             nand_ce_n,
    output logic             nand_we_n,
    output logic             nand_re_n,
    output logic             nand_wp_n,
    output logic [7:0]       nand_io_out,
    output logic             nand_io_oe,
    input  wire logic [7:0]  nand_io_in,
    input  wire logic        ready_busy_n
);
    typedef enum logic [3:0] {
        NFPC_POWERUP  = 4'h0,
        NFPC_IDLE     = 4'h1,
        NFPC_WP_SETUP = 4'h2,
        NFPC_CMD      = 4'h3,
        NFPC_ADDR     = 4'h4,
        NFPC_ADL      = 4'h5,
        NFPC_DATA     = 4'h6,
        NFPC_WB       = 4'h7,
        NFPC_BUSY     = 4'h8,
        NFPC_ST_CMD   = 4'h9,
        NFPC_ST_READ  = 4'hA,
        NFPC_RD_MODE  = 4'hB,
        NFPC_FINISH   = 4'hC
    } nfpc_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [7:0] io_s1_q, io_s2_q;
    logic       rb_s1_q, rb_s2_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
        end else begin
            io_s1_q <= nand_io_in;
            io_s2_q <= io_s1_q;
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe engine
    logic                st_start;
    nfpc_pkg::nfpc_cyc_t st_kind;
    logic [7:0]          st_wdata;
    logic                st_done;
    logic [7:0]          st_rdata;

    nfpc_strobe u_strobe (
        .clk     (clk),
        .rstn    (rstn),
        .start   (st_start),
        .kind    (st_kind),
        .wdata   (st_wdata),
        .io_in_s (io_s2_q),
        .done    (st_done),
        .rdata   (st_rdata),
        .cle     (nand_cle),
        .ale     (nand_ale),
        .we_n    (nand_we_n),
        .re_n    (nand_re_n),
        .io_out  (nand_io_out),
        .io_oe   (nand_io_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    nfpc_state_t                    state_q, state_d;
    logic [nfpc_pkg::TIMER_W-1:0]   tmr_q, tmr_d;
    logic [1:0]                     idx_q, idx_d;
    logic                           rdy_q, busy_d;
    logic [7:0]                     addr_q, addr_d;
    logic [31:0]                    par_q, par_d;
    logic                           poll_q, poll_d;
    logic                           wp_n_q, wp_n_d;
    logic                           done_q, done_d;
    logic [7:0]                     stat_q, stat_d;
    logic                           ce_n_q, ce_n_d;

    function automatic logic [nfpc_pkg::TIMER_W-1:0] cyc(input int unsigned n);
        cyc = nfpc_pkg::TIMER_W'(n);
    endfunction : cyc

    always_comb begin
        state_d  = state_q;
        tmr_d    = tmr_q;
        idx_d    = idx_q;
        busy_d   = 1'b0;
        addr_d   = addr_q;
        par_d    = par_q;
        poll_d   = poll_q;
        wp_n_d   = wp_n_q;
        done_d   = 1'b0;
        stat_d   = stat_q;
        ce_n_d   = ce_n_q;
        st_start = 1'b0;
        st_kind  = nfpc_pkg::NFPC_CYC_CMD;
        st_wdata = 8'h00;
        if (tmr_q != '0) begin
            tmr_d = tmr_q - 1'b1;
        end
        case (state_q)
            NFPC_POWERUP: begin
                busy_d = 1'b1;
                wp_n_d = 1'b0;                                    // RULE15
                if (tmr_q == '0) begin                            // RULE14
                    state_d = NFPC_IDLE;
                    busy_d  = 1'b0;
                end
            end
            NFPC_IDLE: begin
                ce_n_d = 1'b1;
                if (wp_allow != wp_n_q) begin                     // RULE10
                    wp_n_d  = wp_allow;
                    tmr_d   = cyc(nfpc_pkg::PROTECT_SETUP_CYC);   // RULE11
                    state_d = NFPC_WP_SETUP;
                    busy_d  = 1'b1;
                end else if (feat_req) begin
                    addr_d  = feat_addr;
                    par_d   = feat_params;
                    poll_d  = poll_status;
                    ce_n_d  = 1'b0;
                    state_d = NFPC_CMD;
                    busy_d  = 1'b1;
                end
            end
            NFPC_WP_SETUP: begin
                busy_d = 1'b1;
                if (tmr_q == '0) begin
                    state_d = NFPC_IDLE;
                end
            end
            NFPC_CMD: begin
                busy_d   = 1'b1;
                st_start = (tmr_q == '0) && !st_done;
                st_kind  = nfpc_pkg::NFPC_CYC_CMD;
                st_wdata = nfpc_pkg::CMD_SET_FEATURE;             // RULE1
                if (st_done) begin
                    state_d = NFPC_ADDR;
                end
            end
            NFPC_ADDR: begin
                busy_d   = 1'b1;
                st_start = !st_done && (tmr_q == '0);
                st_kind  = nfpc_pkg::NFPC_CYC_ADDR;
                st_wdata = addr_q;                                // RULE1
                if (st_done) begin
                    tmr_d   = cyc(nfpc_pkg::ADDR_TO_DATA_CYC);    // RULE16
                    idx_d   = 2'd0;
                    state_d = NFPC_ADL;
                end
            end
            NFPC_ADL: begin
                busy_d = 1'b1;
                if (tmr_q == '0) begin
                    state_d = NFPC_DATA;
                end
            end
            NFPC_DATA: begin
                busy_d   = 1'b1;
                st_start = !st_done;
                st_kind  = nfpc_pkg::NFPC_CYC_DATA;
                st_wdata = par_q[8*idx_q +: 8];                   // RULE2
                if (st_done) begin
                    if (idx_q == 2'(nfpc_pkg::PARAM_COUNT - 1)) begin
                        tmr_d   = cyc(nfpc_pkg::WE_TO_BUSY_CYC);
                        state_d = NFPC_WB;
                    end else begin
                        idx_d = idx_q + 2'd1;
                        state_d = NFPC_ADL;
                    end
                end
            end
            NFPC_WB: begin
                busy_d = 1'b1;
                if (tmr_q == '0) begin
                    state_d = poll_q ? NFPC_ST_CMD : NFPC_BUSY;
                end
            end
            NFPC_BUSY: begin
                busy_d = 1'b1;
                if (rb_s2_q) begin                                // RULE3 RULE17
                    state_d = NFPC_FINISH;
                end
            end
            NFPC_ST_CMD: begin
                busy_d   = 1'b1;
                st_start = !st_done;
                st_kind  = nfpc_pkg::NFPC_CYC_CMD;
                st_wdata = nfpc_pkg::CMD_READ_STATUS;             // RULE5
                if (st_done) begin
                    state_d = NFPC_ST_READ;
                end
            end
            NFPC_ST_READ: begin
                busy_d   = 1'b1;
                st_start = !st_done;
                st_kind  = nfpc_pkg::NFPC_CYC_READ;
                if (st_done) begin
                    stat_d = st_rdata;
                    if (st_rdata[nfpc_pkg::STATUS_READY_BIT]) begin  // RULE12
                        state_d = NFPC_RD_MODE;
                    end
                end
            end
            NFPC_RD_MODE: begin
                busy_d   = 1'b1;
                st_start = !st_done;
                st_kind  = nfpc_pkg::NFPC_CYC_CMD;
                st_wdata = nfpc_pkg::CMD_READ_MODE;
                if (st_done) begin
                    state_d = NFPC_FINISH;
                end
            end
            NFPC_FINISH: begin
                done_d  = 1'b1;
                ce_n_d  = 1'b1;
                state_d = NFPC_IDLE;
            end
            default: state_d = NFPC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= NFPC_POWERUP;
            tmr_q   <= nfpc_pkg::TIMER_W'(POWER_UP_CYC);
            idx_q   <= 2'd0;
            rdy_q   <= 1'b0;
            addr_q  <= 8'h00;
            par_q   <= 32'h0000_0000;
            poll_q  <= 1'b0;
            wp_n_q  <= 1'b0;
            done_q  <= 1'b0;
            stat_q  <= 8'h00;
            ce_n_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            idx_q   <= idx_d;
            rdy_q   <= !busy_d;
            addr_q  <= addr_d;
            par_q   <= par_d;
            poll_q  <= poll_d;
            wp_n_q  <= wp_n_d;
            done_q  <= done_d;
            stat_q  <= stat_d;
            ce_n_q  <= ce_n_d;
        end
    end

    assign feat_done   = done_q;
    assign status_byte = stat_q;
    assign ctrl_ready  = rdy_q;
    assign nand_ce_n   = ce_n_q;
    assign nand_wp_n   = wp_n_q;
endmodule : nfpc_host
`default_nettype wire

// ---- rtl/nfpc_pkg.sv ----
// Package: constants for the feature-write and protect host controller
package nfpc_pkg;
    localparam int unsigned CLK_HZ             = 20000000;
    localparam int unsigned CLK_PERIOD_NS      = 50;
    // Times in their own units
    localparam int unsigned POWER_UP_WAIT_US   = 1000;
    localparam int unsigned PROTECT_SETUP_NS   = 100;
    localparam int unsigned ADDR_TO_DATA_NS    = 70;
    localparam int unsigned WE_TO_BUSY_NS      = 100;
    localparam int unsigned FEATURE_BUSY_US    = 1;
    // Cycle counts, least times rounded up
    localparam int unsigned POWER_UP_CYC       = POWER_UP_WAIT_US * (CLK_HZ / 1000000);
    localparam int unsigned PROTECT_SETUP_CYC  =
        (PROTECT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_TO_DATA_CYC   =
        (ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WE_TO_BUSY_CYC     =
        (WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FEATURE_BUSY_CYC   = FEATURE_BUSY_US * (CLK_HZ / 1000000);
    // Strobe shaping: each strobe low and high phase in cycles
    localparam int unsigned STROBE_PHASE_CYC   = 1;
    // Extra read-strobe low cycles covering the two-stage input synchroniser
    localparam int unsigned READ_SYNC_CYC      = 3;
    localparam int unsigned TIMER_W            = 16;
    // Command bytes
    localparam logic [7:0]  CMD_SET_FEATURE    = 8'hEF;
    localparam logic [7:0]  CMD_READ_STATUS    = 8'h70;
    localparam logic [7:0]  CMD_READ_MODE      = 8'h00;
    // Status bit for ready
    localparam int unsigned STATUS_READY_BIT   = 5;
    localparam int unsigned PARAM_COUNT        = 4;
    // Bus cycle kinds for the strobe engine
    typedef enum logic [1:0] {
        NFPC_CYC_CMD  = 2'b00,
        NFPC_CYC_ADDR = 2'b01,
        NFPC_CYC_DATA = 2'b10,
        NFPC_CYC_READ = 2'b11
    } nfpc_cyc_t;
endpackage : nfpc_pkg

// ---- rtl/nfpc_strobe.sv ----
// Single bus-cycle engine: drives one write or read strobe cycle on the pins
`timescale 1ns/1ns
`default_nettype none
module nfpc_strobe (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              start,
    input  wire nfpc_pkg::nfpc_cyc_t kind,
    input  wire logic [7:0]        wdata,
    input  wire logic [7:0]        io_in_s,
    output logic                   done,
    output logic [7:0]             rdata,
    output logic                   cle,
    output logic                   ale,
    output logic                   we_n,
    output logic                   re_n,
    output logic [7:0]             io_out,
    output logic                   io_oe
);
    typedef enum logic [1:0] {
        NFPC_S_IDLE = 2'b00,
        NFPC_S_LOW  = 2'b01,
        NFPC_S_HIGH = 2'b10
    } nfpc_sst_t;

    nfpc_sst_t   st_q, st_d;
    logic        cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
    logic [7:0]  io_q, io_d, rd_q, rd_d;
    logic        oe_q, oe_d, done_q, done_d;
    logic        is_rd_q, is_rd_d;
    logic [1:0]  rw_q, rw_d;

    always_comb begin
        st_d    = st_q;
        cle_d   = cle_q;
        ale_d   = ale_q;
        we_n_d  = we_n_q;
        re_n_d  = re_n_q;
        io_d    = io_q;
        oe_d    = oe_q;
        rd_d    = rd_q;
        done_d  = 1'b0;
        is_rd_d = is_rd_q;
        rw_d    = rw_q;
        case (st_q)
            NFPC_S_IDLE: begin
                if (start) begin
                    st_d    = NFPC_S_LOW;
                    is_rd_d = (kind == nfpc_pkg::NFPC_CYC_READ);
                    cle_d   = (kind == nfpc_pkg::NFPC_CYC_CMD);
                    ale_d   = (kind == nfpc_pkg::NFPC_CYC_ADDR);
                    oe_d    = (kind != nfpc_pkg::NFPC_CYC_READ);
                    io_d    = wdata;
                    we_n_d  = (kind == nfpc_pkg::NFPC_CYC_READ);
                    re_n_d  = (kind != nfpc_pkg::NFPC_CYC_READ);
                    rw_d    = (kind == nfpc_pkg::NFPC_CYC_READ) ?
                              2'(nfpc_pkg::READ_SYNC_CYC) : 2'd0;
                end
            end
            NFPC_S_LOW: begin
                // Read strobe stays low until synchronised data has arrived
                if (rw_q != 2'd0) begin
                    rw_d = rw_q - 2'd1;
                end else begin
                    // Rising write strobe latches the byte in the device
                    st_d   = NFPC_S_HIGH;
                    we_n_d = 1'b1;
                    re_n_d = 1'b1;
                    if (is_rd_q) begin
                        rd_d = io_in_s;
                    end
                end
            end
            NFPC_S_HIGH: begin
                st_d   = NFPC_S_IDLE;
                cle_d  = 1'b0;
                ale_d  = 1'b0;
                oe_d   = 1'b0;
                done_d = 1'b1;
            end
            default: st_d = NFPC_S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q    <= NFPC_S_IDLE;
            cle_q   <= 1'b0;
            ale_q   <= 1'b0;
            we_n_q  <= 1'b1;
            re_n_q  <= 1'b1;
            io_q    <= 8'h00;
            oe_q    <= 1'b0;
            rd_q    <= 8'h00;
            done_q  <= 1'b0;
            is_rd_q <= 1'b0;
            rw_q    <= 2'd0;
        end else begin
            st_q    <= st_d;
            cle_q   <= cle_d;
            ale_q   <= ale_d;
            we_n_q  <= we_n_d;
            re_n_q  <= re_n_d;
            io_q    <= io_d;
            oe_q    <= oe_d;
            rd_q    <= rd_d;
            done_q  <= done_d;
            is_rd_q <= is_rd_d;
            rw_q    <= rw_d;
        end
    end

    assign done   = done_q;
    assign rdata  = rd_q;
    assign cle    = cle_q;
    assign ale    = ale_q;
    assign we_n   = we_n_q;
    assign re_n   = re_n_q;
    assign io_out = io_q;
    assign io_oe  = oe_q;
endmodule : nfpc_strobe
`default_nettype wire

// ---- bench/nfpc_host_chk.sv ----
// Checker: pin-level protocol assertions for the host controller
`timescale 1ns/1ns
`default_nettype none
module nfpc_host_chk #(
    parameter int unsigned POWER_UP_CYC = 20000
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        feat_req,
    input wire logic        ctrl_ready,
    input wire logic        feat_done,
    input wire logic        nand_cle,
    input wire logic        nand_ale,
    input wire logic        nand_ce_n,
    input wire logic        nand_we_n,
    input wire logic        nand_re_n,
    input wire logic        nand_wp_n,
    input wire logic [7:0]  nand_io_out,
    input wire logic        nand_io_oe,
    input wire logic        ready_busy_n
);
    ////////////////////////////////////////////////////////////
    // Cycles since reset release, saturating
    logic [15:0] up_q;
    logic [15:0] up_d;
    always_comb begin
        up_d = (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
        if (!rstn) up_d = 16'h0000;
    end
    always_ff @(posedge clk) begin
        up_q <= up_d;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    reset_idle_a: assert property (disable iff (1'b0)
        !rstn |=> nand_ce_n && nand_we_n && nand_re_n && !nand_wp_n && !nand_io_oe && !ctrl_ready)
        else $error("pins not idle after reset");
    power_wait_a: assert property (ctrl_ready |-> up_q >= POWER_UP_CYC)
        else $error("ready before power-up wait");
    wp_steady_a: assert property (!nand_ce_n |=> nand_ce_n || $stable(nand_wp_n))
        else $error("write protect moved during operation");
    wp_setup_a: assert property (
        $changed(nand_wp_n) |-> !($rose(nand_we_n) && nand_cle) [*2])
        else $error("command latched too soon after write protect change");
    addr_gap_a: assert property ($rose(nand_we_n) && nand_ale |=> !$rose(nand_we_n) [*3])
        else $error("data latched too soon after address");
    cmd_addr_a: assert property (
        $rose(nand_we_n) && nand_cle && nand_io_out == nfpc_pkg::CMD_SET_FEATURE
        |-> ##[1:6] ($rose(nand_we_n) && nand_ale)) else $error("no address after feature command");
    latch_drive_a: assert property ($rose(nand_we_n) |-> nand_io_oe && nand_re_n && !nand_ce_n)
        else $error("write latch without driven bus");
    busy_cmd_a: assert property (
        $rose(nand_we_n) && nand_cle && !ready_busy_n |-> nand_io_out == nfpc_pkg::CMD_READ_STATUS)
        else $error("command other than status while busy");
    done_ready_a: assert property (feat_done |-> ready_busy_n && $past(ready_busy_n, 2))
        else $error("done before device ready");
    req_taken_a: assert property (ctrl_ready && feat_req |=> !ctrl_ready)
        else $error("request not taken while ready");
endmodule : nfpc_host_chk
`default_nettype wire

// ---- bench/nfpc_flash_model.sv ----
// Device model: feature byte capture, busy period and status reads
`timescale 1ns/1ns
`default_nettype none
module nfpc_flash_model (
    input  wire logic        clk,
    input  wire logic        nand_cle,
    input  wire logic        nand_ale,
    input  wire logic        nand_ce_n,
    input  wire logic        nand_we_n,
    input  wire logic        nand_re_n,
    input  wire logic        nand_wp_n,
    input  wire logic [7:0]  nand_io_out,
    input  wire logic [4:0]  busy_len,
    output logic [7:0]       nand_io_in,
    output logic             ready_busy_n,
    output logic [7:0]       got_cmd,
    output logic [7:0]       got_addr,
    output logic [31:0]      got_params,
    output logic [7:0]       feat_cnt
);
    logic       we_q = 1'b1;
    logic       feat_mode = 1'b0;
    logic       stat_mode = 1'b0;
    logic [2:0] nbytes = 3'h4;
    logic [4:0] busy_cnt = 5'h00;
    logic [1:0] hold_c = 2'h0;
    logic [7:0] status;
    // Power-on state only; nothing but a power cycle restores it
    initial begin
        got_cmd = 8'h00; got_addr = 8'h00; got_params = 32'h0; feat_cnt = 8'h00;
        nand_io_in = 8'h5A;
    end
    assign ready_busy_n = (busy_cnt == 5'h00);
    assign status = {nand_wp_n, ready_busy_n, ready_busy_n, 5'h00};
    always @(posedge clk) begin
        we_q <= nand_we_n;
        if (busy_cnt != 5'h00) busy_cnt <= busy_cnt - 5'h01;
        if (!nand_ce_n && nand_we_n && !we_q) begin
            if (nand_cle) begin
                got_cmd   <= nand_io_out;
                stat_mode <= (nand_io_out == 8'h70);
                if (nand_io_out == 8'hEF) begin
                    feat_mode <= 1'b1;
                    nbytes    <= 3'h0;
                end
            end else if (nand_ale) begin
                if (feat_mode) got_addr <= nand_io_out;
            end else if (feat_mode && nbytes != 3'h4) begin
                got_params[8*nbytes +: 8] <= nand_io_out;
                nbytes <= nbytes + 3'h1;
                if (nbytes == 3'h3) begin
                    busy_cnt <= busy_len;
                    feat_cnt <= feat_cnt + 8'h01;
                end
            end
        end
        // Released bus shows a changing pattern, not the last value
        if (!nand_ce_n && !nand_re_n && stat_mode) begin
            nand_io_in <= status;
            hold_c     <= 2'h2;
        end else if (hold_c != 2'h0) hold_c <= hold_c - 2'h1;
        else nand_io_in <= ~nand_io_in;
    end
endmodule : nfpc_flash_model
`default_nettype wire

// ---- bench/nfpc_host_tb.sv ----
// Testbench: feature writes, polling, write protect and reset
`timescale 1ns/1ns
`default_nettype none
module nfpc_host_tb;
    localparam int unsigned PU = 10;
    logic        clk = 1'b0, rstn = 1'b0, feat_req = 1'b0, poll_status = 1'b0, wp_allow = 1'b0;
    logic [7:0]  feat_addr = 8'h00;
    logic [31:0] feat_params = 32'h0;
    logic [4:0]  busy_len = 5'h01;
    logic        feat_done, ctrl_ready, nand_cle, nand_ale, nand_ce_n, nand_we_n;
    logic        nand_re_n, nand_wp_n, nand_io_oe, ready_busy_n;
    logic [7:0]  status_byte, nand_io_out, nand_io_in, got_cmd, got_addr, feat_cnt;
    logic [31:0] got_params;
    int          num_errors = 0, check_count = 0, cyc = 0, exp_cnt = 0;
    logic [39:0] exp_q[$];

    always #25 clk = ~clk;
    nfpc_host #(.POWER_UP_CYC(PU)) i_nfpc_host (.clk(clk), .rstn(rstn), .feat_req(feat_req),
        .feat_addr(feat_addr), .feat_params(feat_params), .poll_status(poll_status),
        .wp_allow(wp_allow), .feat_done(feat_done), .status_byte(status_byte),
        .ctrl_ready(ctrl_ready), .nand_cle(nand_cle), .nand_ale(nand_ale),
        .nand_ce_n(nand_ce_n), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
        .nand_wp_n(nand_wp_n), .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe),
        .nand_io_in(nand_io_in), .ready_busy_n(ready_busy_n));
    nfpc_flash_model i_nfpc_flash_model (.clk(clk), .nand_cle(nand_cle), .nand_ale(nand_ale),
        .nand_ce_n(nand_ce_n), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
        .nand_wp_n(nand_wp_n), .nand_io_out(nand_io_out), .busy_len(busy_len),
        .nand_io_in(nand_io_in), .ready_busy_n(ready_busy_n), .got_cmd(got_cmd),
        .got_addr(got_addr), .got_params(got_params), .feat_cnt(feat_cnt));
    ////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic power_up();
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (ctrl_ready !== 1'b1 && n < 100);
        chk(40'(n > PU && ctrl_ready === 1'b1), 40'h1, "power-up wait");
    endtask : power_up

    task automatic feat_op(input logic do_reset);
        logic [39:0] e;
        int          n;
        e = {8'($urandom), 32'($urandom)};
        @(posedge clk);
        wp_allow    <= 1'($urandom);
        poll_status <= 1'($urandom);
        busy_len    <= 5'($urandom_range(20, 1));
        repeat (3) @(posedge clk);
        n = 0;
        do begin @(posedge clk); #1; n++; end while (ctrl_ready !== 1'b1 && n < 100);
        chk(40'(ctrl_ready), 40'h1, "ready before request");
        @(posedge clk);
        feat_req    <= 1'b1;
        feat_addr   <= e[39:32];
        feat_params <= e[31:0];
        @(posedge clk);
        feat_req <= 1'b0;
        if (do_reset) begin
            repeat (3) @(posedge clk);
            rstn <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk(40'({nand_wp_n, nand_ce_n, ctrl_ready}), 40'h2, "pins in reset");
            @(posedge clk);
            rstn <= 1'b1;
            power_up();
            return;
        end
        exp_cnt++;
        exp_q.push_back(e);
        n = 0;
        do begin
            @(posedge clk);
            feat_req <= (n == 6);
            #1;
            n++;
        end while (feat_done !== 1'b1 && n < 400);
        e = exp_q.pop_front();
        chk(40'(feat_done), 40'h1, "done pulse seen");
        chk(40'(n > busy_len), 40'h1, "done before busy end");
        chk({got_addr, got_params}, e, "address and params");
        chk(40'(feat_cnt), 40'(exp_cnt), "extra request taken");
        chk(40'(got_cmd), poll_status ? 40'h00 : 40'hEF, "last command");
        chk(40'(nand_wp_n), 40'(wp_allow), "write protect level");
        if (poll_status) chk(40'(status_byte), {32'h0, wp_allow, 7'h60}, "status");
    endtask : feat_op
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h4C11));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        power_up();
        for (int i = 0; i < 10; i++) feat_op(i == 4);
        give_verdict();
    end
endmodule : nfpc_host_tb

bind nfpc_host nfpc_host_chk #(.POWER_UP_CYC(POWER_UP_CYC)) i_nfpc_host_chk (
    .clk(clk), .rstn(rstn), .feat_req(feat_req), .ctrl_ready(ctrl_ready),
    .feat_done(feat_done), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_ce_n(nand_ce_n),
    .nand_we_n(nand_we_n), .nand_re_n(nand_re_n), .nand_wp_n(nand_wp_n),
    .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire
